/* logic/qfp_sequencer.sv */
// Purpose: factory program command sequencer (double, quad, enhanced, quad
//          enhanced) with status byte and array-engine word stream
// Assumes: bus writes arrive as one-cycle strobes on ref_clk
// Notes: reset_pin_n is an outside pin and is synchronised here

// Notes on behaviour
// - no dual read, no suspend while active
// - 75h setup starts load, reads give status
// - load takes four writes, no early leave
// - later page: start address steps page
// - FFFFh outside start block exits
// - address checked on first page word only
// - program, verify, reprogram failing page automatically
// - program-verify shows idle 0, ready 1
// - one write after verify restarts loading
// - exit to read mode, flag failures
// - double word: 35h then two words
// - quad word: 56h then four words
// - enhanced: 30h, D0h, stream, FFFFh, verify stream, FFFFh exit
// - setup and confirm accepted at any address
// - load and program repeat for any pages in the stream modes
// - idle bit low while controller active
// - ready bit tracks current word progress
module qfp_sequencer #(
    parameter int BLK_BITS = qfp_pkg::BLK_BITS,
    parameter int MAX_RETRY = qfp_pkg::MAX_RETRY,
    parameter int FIFO_DEPTH = qfp_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic wr_strobe,
    input wire logic [qfp_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [qfp_pkg::DATA_W-1:0] wr_data,
    output logic [7:0] stat,
    output logic stat_sel,
    output logic no_dual_op,
    output logic bus_wait,
    output logic arr_valid,
    output qfp_pkg::qfp_word_s arr_word,
    input wire logic arr_ready,
    input wire logic arr_done,
    input wire logic arr_fail
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic same_block(
        input logic [qfp_pkg::ADDR_W-1:0] a,
        input logic [qfp_pkg::ADDR_W-1:0] b
    );
        same_block = a[qfp_pkg::ADDR_W-1:BLK_BITS] ==
            b[qfp_pkg::ADDR_W-1:BLK_BITS];
    endfunction

    function automatic logic [2:0] need_words(input qfp_pkg::qfp_mode_e m);
        if (m == qfp_pkg::MODE_DW) begin
            need_words = qfp_pkg::DW_WORDS;
        end else if (m == qfp_pkg::MODE_EFP) begin
            need_words = qfp_pkg::EFP_WORDS;
        end else begin
            need_words = qfp_pkg::QW_WORDS;
        end
    endfunction

    // ----------------------------------------------------------------
    // reset pin synchroniser
    // ----------------------------------------------------------------
    logic [2:0] rp_sync;
    logic rp_level;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rp_sync <= qfp_pkg::SYNC_RST;
            rp_level <= 1'b1;
        end else begin
            rp_sync <= {rp_sync[1:0], reset_pin_n};
            if (rp_sync[1] == rp_sync[2]) begin
                rp_level <= rp_sync[2];
            end
        end
    end

    wire abort = !rp_level;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    qfp_pkg::qfp_state_e state, next_state;
    qfp_pkg::qfp_mode_e mode, next_mode;
    logic [2:0] cnt, next_cnt;
    logic [2:0] done_cnt, next_done;
    logic fail_seen, next_fail;
    logic [3:0] retry, next_retry;
    logic err, next_err;
    logic first, next_first;
    logic ver, next_ver;
    logic [qfp_pkg::ADDR_W-1:0] start, next_start;
    logic [qfp_pkg::ADDR_W-1:0] base, next_base;
    logic [qfp_pkg::ADDR_W-1:0] last, next_last;
    qfp_pkg::qfp_word_s page [4];

    logic push_valid;
    qfp_pkg::qfp_word_s push_word;
    logic page_we;
    logic fifo_in_ready;

    // ----------------------------------------------------------------
    // address and data decoding
    // ----------------------------------------------------------------
    wire [2:0] need = need_words(mode);
    wire [7:0] cmd = wr_data[7:0];
    wire off_block = !same_block(wr_addr, start);
    wire is_stream = mode == qfp_pkg::MODE_QEFP ||
        mode == qfp_pkg::MODE_EFP;
    wire exit_hit = is_stream && !first && cnt == 3'h0 &&
        wr_data == qfp_pkg::EXIT_DATA && off_block;
    // out-of-block data on a page's first word, other than the exit value, is ignored
    wire stray = is_stream && !first && cnt == 3'h0 && off_block;
    // start address again means next page / next word
    wire at_start = !first && wr_addr == start;
    wire [qfp_pkg::ADDR_W-1:0] first_addr =
        at_start ? base + qfp_pkg::PAGE_STEP : wr_addr;
    wire [qfp_pkg::ADDR_W-1:0] efp_addr =
        at_start ? last + 1'b1 : wr_addr;
    // later page words take their slot from the count alone
    wire [qfp_pkg::ADDR_W-1:0] slot_addr =
        mode == qfp_pkg::MODE_DW ? {base[qfp_pkg::ADDR_W-1:1], cnt[0]} :
        {base[qfp_pkg::ADDR_W-1:2], cnt[1:0]};
    wire [qfp_pkg::ADDR_W-1:0] cur_addr =
        mode == qfp_pkg::MODE_EFP ? efp_addr :
        cnt == 3'h0 ? first_addr : slot_addr;
    wire retry_left = retry < 4'(MAX_RETRY);
    wire page_done = done_cnt == need;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_cnt = cnt;
        next_done = done_cnt;
        next_fail = fail_seen;
        next_retry = retry;
        next_err = err;
        next_first = first;
        next_ver = ver;
        next_start = start;
        next_base = base;
        next_last = last;
        push_valid = 1'b0;
        page_we = 1'b0;
        push_word = '{verify: ver, addr: cur_addr, data: wr_data};
        // answers may come back before the last word of a page is loaded
        if (arr_done) begin
            next_done = done_cnt + 3'h1;
            next_fail = fail_seen || arr_fail;
        end
        case (state)
            qfp_pkg::S_IDLE: begin
                next_cnt = 3'h0;
                next_first = 1'b1;
                next_ver = 1'b0;
                // setup is decoded at any address of the bank
                if (wr_strobe) begin
                    if (cmd == qfp_pkg::CMD_QEFP) begin
                        next_mode = qfp_pkg::MODE_QEFP;
                        next_state = qfp_pkg::S_LOAD;
                    end else if (cmd == qfp_pkg::CMD_DW) begin
                        next_mode = qfp_pkg::MODE_DW;
                        next_state = qfp_pkg::S_LOAD;
                    end else if (cmd == qfp_pkg::CMD_QW) begin
                        next_mode = qfp_pkg::MODE_QW;
                        next_state = qfp_pkg::S_LOAD;
                    end else if (cmd == qfp_pkg::CMD_EFP) begin
                        next_mode = qfp_pkg::MODE_EFP;
                        next_state = qfp_pkg::S_CONF;
                    end
                end
            end
            qfp_pkg::S_CONF: begin
                if (wr_strobe) begin
                    next_state = cmd == qfp_pkg::CMD_CONFIRM ?
                        qfp_pkg::S_LOAD : qfp_pkg::S_IDLE;
                end
            end
            qfp_pkg::S_LOAD: begin
                if (wr_strobe && exit_hit) begin
                    if (mode == qfp_pkg::MODE_EFP && !ver) begin
                        next_ver = 1'b1;
                        next_last = start - 1'b1;
                    end else begin
                        next_state = qfp_pkg::S_IDLE;
                    end
                end else if (wr_strobe && !stray && fifo_in_ready) begin
                    // every write of the load is data, any code included
                    push_valid = 1'b1;
                    page_we = 1'b1;
                    next_cnt = cnt + 3'h1;
                    next_last = cur_addr;
                    next_first = 1'b0;
                    if (first) begin
                        next_start = wr_addr;
                    end
                    if (cnt == 3'h0) begin
                        next_base = cur_addr;
                        next_done = 3'h0;
                        next_fail = 1'b0;
                    end
                    if (cnt + 3'h1 == need) begin
                        next_state = qfp_pkg::S_RUN;
                        next_retry = 4'h0;
                    end
                end
            end
            qfp_pkg::S_RUN: begin
                if (page_done && fail_seen && retry_left) begin
                    next_state = qfp_pkg::S_RETRY;
                    next_cnt = 3'h0;
                    next_retry = retry + 4'h1;
                    next_done = 3'h0;
                    next_fail = 1'b0;
                end else if (page_done) begin
                    next_err = err || fail_seen;
                    next_cnt = 3'h0;
                    next_state = is_stream ?
                        qfp_pkg::S_LOAD : qfp_pkg::S_IDLE;
                end
            end
            qfp_pkg::S_RETRY: begin
                push_word = page[cnt[1:0]];
                if (fifo_in_ready) begin
                    push_valid = 1'b1;
                    next_cnt = cnt + 3'h1;
                    if (cnt + 3'h1 == need) begin
                        next_state = qfp_pkg::S_RUN;
                    end
                end
            end
            default: begin
                next_state = qfp_pkg::S_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst || abort) begin
            state <= qfp_pkg::S_IDLE;
            mode <= qfp_pkg::MODE_QEFP;
            cnt <= 3'h0;
            done_cnt <= 3'h0;
            fail_seen <= 1'b0;
            retry <= 4'h0;
            err <= 1'b0;
            first <= 1'b1;
            ver <= 1'b0;
            start <= '0;
            base <= '0;
            last <= '0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            cnt <= next_cnt;
            done_cnt <= next_done;
            fail_seen <= next_fail;
            retry <= next_retry;
            err <= next_err;
            first <= next_first;
            ver <= next_ver;
            start <= next_start;
            base <= next_base;
            last <= next_last;
        end
    end

    // page copy kept for reprogramming without the host
    always_ff @(posedge ref_clk) begin
        if (page_we) begin
            page[cnt[1:0]] <= push_word;
        end
    end

    // ----------------------------------------------------------------
    // status and bus-side outputs
    // ----------------------------------------------------------------
    wire next_active = next_state != qfp_pkg::S_IDLE;
    wire next_busy = next_state == qfp_pkg::S_RUN ||
        next_state == qfp_pkg::S_RETRY;
    // plain word modes show status only once programming has begun
    wire next_sel = next_busy || (next_active &&
        next_mode != qfp_pkg::MODE_DW && next_mode != qfp_pkg::MODE_QW);

    always_ff @(posedge ref_clk) begin
        if (rst || abort) begin
            stat <= qfp_pkg::STAT_RST;
            stat_sel <= 1'b0;
            no_dual_op <= 1'b0;
            bus_wait <= 1'b0;
        end else begin
            stat <= '0;
            stat[qfp_pkg::ST_IDLE] <= !next_active;
            stat[qfp_pkg::ST_PERR] <= next_err;
            stat[qfp_pkg::ST_WRDY] <= next_busy;
            stat_sel <= next_sel;
            no_dual_op <= next_active;
            bus_wait <= !fifo_in_ready;
        end
    end

    // ----------------------------------------------------------------
    // word buffer toward the array engine
    // ----------------------------------------------------------------
    qfp_fifo #(
        .WIDTH(qfp_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(abort),
        .in_valid(push_valid),
        .in_data(push_word),
        .in_ready(fifo_in_ready),
        .out_ready(arr_ready),
        .out_valid(arr_valid),
        .out_data(arr_word)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || abort || !rp_level);

    setup_status_a: assert property (
        state == qfp_pkg::S_IDLE && wr_strobe && cmd == qfp_pkg::CMD_QEFP
        |=> stat_sel && !stat[qfp_pkg::ST_IDLE] && no_dual_op)
        else $error("setup did not enter status mode");
    load_hold_a: assert property (
        state == qfp_pkg::S_LOAD && cnt != 3'h0
        |=> state != qfp_pkg::S_IDLE)
        else $error("load left before four words");
    pv_status_a: assert property (
        state == qfp_pkg::S_RUN
        |-> !stat[qfp_pkg::ST_IDLE] && stat[qfp_pkg::ST_WRDY])
        else $error("wrong status during program-verify");
    exit_read_a: assert property (
        state == qfp_pkg::S_LOAD && mode == qfp_pkg::MODE_QEFP &&
        wr_strobe && exit_hit
        |=> stat[qfp_pkg::ST_IDLE] && !stat_sel)
        else $error("exit write did not end the sequence");
    confirm_bad_a: assert property (
        state == qfp_pkg::S_CONF && wr_strobe &&
        cmd != qfp_pkg::CMD_CONFIRM
        |=> state == qfp_pkg::S_IDLE)
        else $error("bad confirm not dropped");
    dual_block_a: assert property (
        !stat[qfp_pkg::ST_IDLE] |-> no_dual_op)
        else $error("dual operation allowed while active");
    dw_start_a: assert property (
        state == qfp_pkg::S_LOAD && mode == qfp_pkg::MODE_DW &&
        cnt == 3'h1 && wr_strobe && fifo_in_ready
        |=> state == qfp_pkg::S_RUN ##0 $past(cnt) == 3'h1)
        else $error("double word did not start on second word");
    qw_start_a: assert property (
        state == qfp_pkg::S_LOAD && mode == qfp_pkg::MODE_QW &&
        cnt == 3'h3 && wr_strobe && fifo_in_ready
        |=> state == qfp_pkg::S_RUN ##1 stat[qfp_pkg::ST_WRDY])
        else $error("quad word did not start on fourth word");
    page_again_a: assert property (
        state == qfp_pkg::S_RUN && mode == qfp_pkg::MODE_QEFP &&
        page_done && !fail_seen
        |=> state == qfp_pkg::S_LOAD && cnt == 3'h0)
        else $error("no return to load after verify");
    retry_page_a: assert property (
        state == qfp_pkg::S_RUN && page_done && fail_seen && retry_left
        |=> state == qfp_pkg::S_RETRY ##[1:8] state == qfp_pkg::S_RUN)
        else $error("failed page not reprogrammed");

endmodule

/* include/qfp_pkg.sv */
// Purpose: shared constants and types of the factory program sequencer
// Assumes: 16-bit data bus, 23-bit word address
// Notes: command codes are compared on the low data byte

package qfp_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    // block size is a plain default, not a figure of the array
    localparam int BLK_BITS = 15;

    // ----------------------------------------------------------------
    // command codes and data values
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_QEFP = 8'h75;
    localparam logic [7:0] CMD_DW = 8'h35;
    localparam logic [7:0] CMD_QW = 8'h56;
    localparam logic [7:0] CMD_EFP = 8'h30;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [15:0] EXIT_DATA = 16'hffff;

    // ----------------------------------------------------------------
    // status byte layout and reset value
    // ----------------------------------------------------------------
    localparam int ST_IDLE = 7;
    localparam int ST_PERR = 4;
    localparam int ST_WRDY = 0;
    localparam logic [7:0] STAT_RST = 8'h80;

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    localparam logic [2:0] DW_WORDS = 3'h2;
    localparam logic [2:0] QW_WORDS = 3'h4;
    localparam logic [2:0] EFP_WORDS = 3'h1;
    localparam logic [ADDR_W-1:0] PAGE_STEP = 23'h000004;
    localparam int MAX_RETRY = 3;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] SYNC_RST = 3'h7;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_QEFP = 2'h0,
        MODE_DW = 2'h1,
        MODE_QW = 2'h2,
        MODE_EFP = 2'h3
    } qfp_mode_e;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_CONF = 5'h02,
        S_LOAD = 5'h04,
        S_RUN = 5'h08,
        S_RETRY = 5'h10
    } qfp_state_e;

    typedef struct packed {
        logic verify;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } qfp_word_s;

    localparam int WORD_W = $bits(qfp_word_s);

endpackage

/* logic/qfp_fifo.sv */
// Purpose: word buffer between the command sequencer and the array engine
// Assumes: DEPTH is a power of two
// Notes: read data come out of a register; flush empties it at once

module qfp_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    input wire logic out_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;

    wire push = in_valid && in_ready;
    wire pop = (count != '0) && (!out_valid || out_ready);

    assign in_ready = count != (AW + 1)'(DEPTH);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wp <= push ? wp + 1'b1 : wp;
            rp <= pop ? rp + 1'b1 : rp;
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
            out_valid <= pop || (out_valid && !out_ready);
            out_data <= pop ? mem[rp] : out_data;
        end
    end

endmodule

/* tb/qfp_array_model.sv */
// Purpose: array engine on the far side of the sequencer word stream
// Assumes: one word in flight at a time
// Notes: answers alternate between prompt and slow

module qfp_array_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fail_all,
    input wire logic arr_valid,
    input wire qfp_pkg::qfp_word_s arr_word,
    output logic arr_ready,
    output logic arr_done,
    output logic arr_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    qfp_pkg::qfp_word_s log_q[$];
    logic [2:0] wait_cnt = 3'h0;
    logic pend = 1'b0;
    logic slow = 1'b0;
    assign arr_ready = !pend && !rst;
    initial begin
        arr_done = 1'b0;
        arr_fail = 1'b0;
    end
    // ------------------------------------------------------------
    // take a word, program and verify it, answer later
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        arr_done <= 1'b0;
        // fail means nothing outside done, so it keeps moving
        arr_fail <= ~arr_fail;
        if (rst) begin
            pend <= 1'b0;
        end else if (pend) begin
            wait_cnt <= wait_cnt - 3'h1;
            if (wait_cnt == 3'h0) begin
                pend <= 1'b0;
                arr_done <= 1'b1;
                arr_fail <= fail_all;
            end
        end else if (arr_valid) begin
            log_q.push_back(arr_word);
            pend <= 1'b1;
            slow <= ~slow;
            wait_cnt <= slow ? 3'h6 : 3'h0;
        end
    end
endmodule

/* tb/qfp_sequencer_tb.sv */
// Purpose: self-checking bench of the factory program sequencer
// Assumes: host waits for word ready 0 after every write of the table
// Notes: word buffer is stalled by holding the array model in reset

module qfp_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [22:0] a;
        logic [15:0] d;
        logic [7:0] st;
        logic act;
        logic [3:0] fl;
        logic [22:0] ea;
    } qfp_row_s;
    localparam logic [22:0] SA = 23'h000100;
    localparam logic [22:0] OA = 23'h010000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic wr_strobe = 1'b0;
    logic [22:0] wr_addr = 23'h0;
    logic [15:0] wr_data = 16'h0;
    logic fail_all = 1'b0;
    logic [7:0] stat;
    logic stat_sel, no_dual_op, bus_wait, arr_valid, arr_ready;
    logic arr_done, arr_fail;
    qfp_pkg::qfp_word_s arr_word;
    qfp_pkg::qfp_word_s exp_q[$];
    logic hold_arr = 1'b0;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    // flags: check, busy after write, word goes to array, verify
    qfp_row_s rows[31] = '{
        '{23'h004000,16'h0075,8'h00,1'b1,4'b1000,23'h0},
        '{SA,16'h1111,8'h00,1'b1,4'b1010,23'h100},
        '{OA,16'hffff,8'h00,1'b1,4'b1010,23'h101},
        '{23'h5,16'h0070,8'h00,1'b1,4'b1010,23'h102},
        '{SA,16'h4444,8'h00,1'b1,4'b1110,23'h103},
        '{SA,16'h5555,8'h00,1'b1,4'b1010,23'h104},
        '{23'h7fff,16'h6666,8'h00,1'b1,4'b1010,23'h105},
        '{OA,16'h7777,8'h00,1'b1,4'b1010,23'h106},
        '{23'h1,16'h8888,8'h00,1'b1,4'b1110,23'h107},
        '{OA,16'hffff,8'h80,1'b0,4'b1000,23'h0},
        '{23'h004000,16'h0035,8'h00,1'b0,4'b0000,23'h0},
        '{23'h200,16'haaaa,8'h00,1'b0,4'b0010,23'h200},
        '{23'h201,16'hbbbb,8'h80,1'b0,4'b1110,23'h201},
        '{23'h000300,16'h0056,8'h00,1'b0,4'b0000,23'h0},
        '{23'h300,16'h1234,8'h00,1'b0,4'b0010,23'h300},
        '{23'h301,16'h2345,8'h00,1'b0,4'b0010,23'h301},
        '{23'h302,16'h3456,8'h00,1'b0,4'b0010,23'h302},
        '{23'h303,16'h4567,8'h80,1'b0,4'b1110,23'h303},
        '{23'h004000,16'h0030,8'h00,1'b0,4'b0000,23'h0},
        '{23'h007ff0,16'h0012,8'h80,1'b0,4'b1000,23'h0},
        '{23'h004000,16'h0030,8'h00,1'b0,4'b0000,23'h0},
        '{23'h007ff0,16'h00d0,8'h00,1'b0,4'b0000,23'h0},
        '{23'h400,16'h5a5a,8'h00,1'b1,4'b1010,23'h400},
        '{23'h400,16'h6b6b,8'h00,1'b1,4'b1010,23'h401},
        '{23'h410,16'h7c7c,8'h00,1'b1,4'b1010,23'h410},
        '{OA,16'h1234,8'h00,1'b1,4'b1000,23'h0},
        '{OA,16'hffff,8'h00,1'b0,4'b0000,23'h0},
        '{23'h400,16'h5a5a,8'h00,1'b1,4'b1011,23'h400},
        '{23'h400,16'h6b6b,8'h00,1'b1,4'b1011,23'h401},
        '{23'h410,16'h7c7c,8'h00,1'b1,4'b1011,23'h410},
        '{OA,16'hffff,8'h80,1'b0,4'b1000,23'h0}
    };

    qfp_sequencer dut (.ref_clk(ref_clk), .rst(rst),
        .reset_pin_n(reset_pin_n), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .stat(stat),
        .stat_sel(stat_sel), .no_dual_op(no_dual_op), .bus_wait(bus_wait),
        .arr_valid(arr_valid), .arr_word(arr_word), .arr_ready(arr_ready),
        .arr_done(arr_done), .arr_fail(arr_fail));
    qfp_array_model model (.ref_clk(ref_clk),
        .rst(rst || !reset_pin_n || hold_arr),
        .fail_all(fail_all), .arr_valid(arr_valid), .arr_word(arr_word),
        .arr_ready(arr_ready), .arr_done(arr_done), .arr_fail(arr_fail));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cyc();
        @(posedge ref_clk);
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        cyc();
        wr_strobe <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        cyc();
        wr_strobe <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
        #1;
    endtask
    // the host polls word ready before its next write
    task automatic wait_ready();
        for (int k = 0; k < 400 && stat[0] !== 1'b0; k++) begin
            cyc();
            #1;
        end
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (10) cyc();
        rst <= 1'b0;
        #1;
        chk(40'(stat), 40'(qfp_pkg::STAT_RST));
        chk(40'({stat_sel, no_dual_op, bus_wait, arr_valid}), 40'h0);
        // ------------------------------------------------------------
        // table of command sequences
        // ------------------------------------------------------------
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            if (rows[i].fl[2])
                chk(40'(stat), 40'h01);
            wait_ready();
            if (rows[i].fl[3]) begin
                chk(40'(stat), 40'(rows[i].st));
                chk(40'(stat_sel), 40'(rows[i].act));
                chk(40'(no_dual_op), 40'(rows[i].act));
            end
            if (rows[i].fl[1])
                exp_q.push_back({rows[i].fl[0], rows[i].ea, rows[i].d});
        end
        chk(40'(model.log_q.size()), 40'(exp_q.size()));
        foreach (exp_q[i])
            chk(40'(model.log_q[i]), 40'(exp_q[i]));
        // ------------------------------------------------------------
        // every verify fails: replays run out, error is flagged
        // ------------------------------------------------------------
        fail_all <= 1'b1;
        wr(SA, 16'h0075);
        for (int k = 0; k < 4; k++)
            wr(SA, 16'h00aa);
        wait_ready();
        wr(OA, qfp_pkg::EXIT_DATA);
        chk(40'(stat), 40'h90);
        fail_all <= 1'b0;
        // ------------------------------------------------------------
        // reset pin in mid-load aborts and clears the error
        // ------------------------------------------------------------
        wr(SA, 16'h0075);
        wr(SA, 16'h0101);
        chk(40'(stat), 40'h10);
        cyc();
        reset_pin_n <= 1'b0;
        repeat (6) cyc();
        #1;
        chk(40'(stat), 40'(qfp_pkg::STAT_RST));
        chk(40'({stat_sel, no_dual_op, arr_valid}), 40'h0);
        cyc();
        reset_pin_n <= 1'b1;
        repeat (6) cyc();
        // ------------------------------------------------------------
        // word buffer: engine stalled, offer must stand, then drain
        // ------------------------------------------------------------
        hold_arr <= 1'b1;
        wr(SA, 16'h0075);
        for (int k = 0; k < 4; k++)
            wr(SA, 16'(k));
        repeat (4) cyc();
        #1;
        chk(40'(arr_valid), 40'h1);
        chk(40'(arr_word), {1'b0, SA, 16'h0000});
        n = model.log_q.size();
        cyc();
        hold_arr <= 1'b0;
        wait_ready();
        chk(40'(model.log_q.size() - n), 40'h4);
        chk(40'(model.log_q[n + 3]), {1'b0, SA + 23'h3, 16'h0003});
        end_sim();
    end
endmodule
